// >>> rtl/sms_pkg.sv
// sms_pkg: constants and state types of the serial master/slave port
// assumes: included first; no other package needed
package sms_pkg;

	// ****************
	// * constants
	// ****************
	localparam int         DATA_W    = 8;
	localparam logic [4:0] EDGE_SCK  = 5'h10;
	localparam logic [4:0] EDGE_END  = 5'h11;
	localparam logic [4:0] TX_LAST   = 5'h0E;
	localparam logic [4:0] CAP_FIRST = 5'h02;
	localparam logic [2:0] RATE_MAX  = 3'h5;
	localparam logic [6:0] HALF_MIN  = 7'h02;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST  = 3'h7;

	// ****************
	// * types
	// ****************
	typedef enum logic [0:0] {
		SMS_IDLE = 1'b0,
		SMS_RUN  = 1'b1
	} sms_mst_e;

	typedef struct packed {
		sms_mst_e   st;
		logic [6:0] tmr;
		logic [4:0] edg;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] hold;
		logic [7:0] rdata;
		logic       sck;
		logic       mosi;
		logic       sck_oe;
		logic       miso_oe;
		logic       transfer_done_flag;
		logic       write_collision_flag;
		logic       master_fault_flag;
		logic       overrun_flag;
		logic       arm;
		logic       master_fault_flag_arm;
		logic       master_select_bit;
		logic       port_enable_bit;
		logic       lnk_en;
		logic       irq;
		logic       busy;
		logic       ss_seen;
		logic       ss_m;
		logic       ss_s;
		logic       miso_m;
		logic       miso_s;
		logic       tg_m;
		logic       tg_s;
		logic       tg_d;
	} sms_top_s;

	typedef struct packed {
		logic [2:0] cnt;
	} sms_cnt_s;

	typedef struct packed {
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [7:0] word;
		logic       tgl;
	} sms_dat_s;

endpackage : sms_pkg

// >>> rtl/sms_port.sv
// sms_port: serial port, master or slave, four-wire link
// assumes: cpu strobes are one-cycle pulses on CLK; slave SCK is the
// link clock; configuration inputs held still while the port is busy
// Function
// - bytes shift msb first on both data lines
// - only the master starts; slave waits for master clock edges
// - slave returns its byte on MISO while MOSI shifts in
// - both ends use the same polarity and phase setting
// - six master rates, fastest a quarter of the cpu clock
// - SCK driven as master, input as slave
// - active-low select acts as chip select, one slave at a time
// - software select management ignores the select pin
// - under software management internal select equals level bit
// - phase 0 slave write without select high flags collision
// - master outputs SCK with programmed rate, polarity, phase
// - master bit, and the enable bit of a master, stay set only while select high
// - master transfer starts on data write into shift register
// - done, collision, fault and overrun flags are provided
// - done flag set per byte; data writes blocked until status read
// - select low as master: fault, clear enable and master bits
// - byte with done still set: overrun, keep the older byte
// - write during transfer discarded, collision flag, no interrupt; a phase 1 slave stores the write in hold, no flag
`timescale 1ns/1ps

// ****************
// * link: bit counter, reset between bytes by select
// ****************
module sms_lnk_cnt
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// count
	output      logic [2:0] cnt
);
	sms_pkg::sms_cnt_s s;
	sms_pkg::sms_cnt_s next_s;

	always_comb
	begin
		next_s     = s;
		next_s.cnt = s.cnt + 3'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign cnt = s.cnt;
endmodule : sms_lnk_cnt

// ****************
// * link: slave shift registers and received word
// ****************
module sms_lnk_dat
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// link side
	input  wire logic [2:0] cnt,
	input  wire logic       mosi,
	output      logic       miso,
	// cpu side, hold is quasi-static while a byte runs
	input  wire logic [7:0] hold,
	output      logic [7:0] word,
	output      logic       tgl
);
	sms_pkg::sms_dat_s s;
	sms_pkg::sms_dat_s next_s;

	always_comb
	begin
		next_s       = s;
		next_s.rx_sh = {s.rx_sh[6:0], mosi};
		if (cnt == sms_pkg::BIT_FIRST)
			next_s.tx_sh = {hold[6:0], 1'b0};
		else
			next_s.tx_sh = {s.tx_sh[6:0], 1'b0};
		if (cnt == sms_pkg::BIT_LAST)
		begin
			next_s.word = next_s.rx_sh;
			next_s.tgl  = ~s.tgl;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// first bit stands before any edge; later bits follow each sample
	assign miso = (cnt == sms_pkg::BIT_FIRST) ? hold[7] : s.tx_sh[7];
	assign word = s.word;
	assign tgl  = s.tgl;
endmodule : sms_lnk_dat

// ****************
// * top
// ****************
module sms_port
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	// link pins
	input  wire logic       SCK_I,
	output      logic       SCK_O,
	output      logic       SCK_OE,
	input  wire logic       MOSI_I,
	output      logic       MOSI_O,
	output      logic       MOSI_OE,
	input  wire logic       MISO_I,
	output      logic       MISO_O,
	output      logic       MISO_OE,
	input  wire logic       SEL_N_I,
	// configuration levels
	input  wire logic       CLOCK_IDLE_POLARITY,
	input  wire logic       CLOCK_SAMPLE_PHASE,
	input  wire logic [2:0] BIT_RATE_SELECT,
	input  wire logic       SELECT_SOFTWARE_MANAGED,
	input  wire logic       SELECT_INTERNAL_LEVEL,
	input  wire logic       PORT_INTERRUPT_ENABLE,
	// cpu strobes
	input  wire logic       CTRL_WR,
	input  wire logic       CTRL_MASTER,
	input  wire logic       CTRL_ENABLE,
	input  wire logic       STATUS_ACC,
	input  wire logic       DATA_WR,
	input  wire logic [7:0] DATA_WDATA,
	input  wire logic       DATA_RD,
	// status
	output      logic [7:0] DATA_RDATA,
	output      logic       TRANSFER_DONE_FLAG,
	output      logic       WRITE_COLLISION_FLAG,
	output      logic       MASTER_FAULT_FLAG,
	output      logic       OVERRUN_FLAG,
	output      logic       MASTER_SELECT_BIT,
	output      logic       PORT_ENABLE_BIT,
	output      logic       IRQ,
	output      logic       BUSY
);
	sms_pkg::sms_top_s s;
	sms_pkg::sms_top_s next_s;
	logic       clock_idle_polarity;
	logic       clock_sample_phase;
	logic       ss_int;
	logic       lnk_clk;
	logic       lnk_rst_n;
	logic [2:0] lnk_cnt;
	logic [7:0] lnk_word;
	logic       lnk_tgl;
	logic       miso_lnk;
	logic [2:0] rate;
	logic [6:0] half;
	logic [4:0] k;
	logic [4:0] cap_min;
	logic [4:0] tx_max;
	logic [7:0] rxv;
	logic [7:0] byte_v;
	logic       bdone;
	logic       blocked;

	assign clock_idle_polarity = CLOCK_IDLE_POLARITY;
	assign clock_sample_phase = CLOCK_SAMPLE_PHASE;

	// ****************
	// * slave select and link domain
	// ****************
	assign ss_int = SELECT_SOFTWARE_MANAGED ? SELECT_INTERNAL_LEVEL
		: s.ss_s;
	// sample edge is always the rising edge of the link clock
	assign lnk_clk = SCK_I ^ (clock_idle_polarity ^ clock_sample_phase);
	// counter restarts whenever select is high or the slave is off
	assign lnk_rst_n = ARST_N & s.lnk_en & ~(SELECT_SOFTWARE_MANAGED
		? SELECT_INTERNAL_LEVEL : SEL_N_I);

	sms_lnk_cnt u_cnt
	(
		.clk   (lnk_clk),
		.rst_n (lnk_rst_n),
		.cnt   (lnk_cnt)
	);

	sms_lnk_dat u_dat
	(
		.clk   (lnk_clk),
		.rst_n (ARST_N),
		.cnt   (lnk_cnt),
		.mosi  (MOSI_I),
		.miso  (miso_lnk),
		.hold  (s.hold),
		.word  (lnk_word),
		.tgl   (lnk_tgl)
	);

	// ****************
	// * cpu domain
	// ****************
	assign rate    = (BIT_RATE_SELECT > sms_pkg::RATE_MAX)
		? sms_pkg::RATE_MAX : BIT_RATE_SELECT;
	assign half    = sms_pkg::HALF_MIN << rate;
	assign cap_min = sms_pkg::CAP_FIRST + {4'h0, clock_sample_phase};
	assign tx_max  = sms_pkg::TX_LAST + {4'h0, clock_sample_phase};
	assign blocked = s.transfer_done_flag && !s.arm;

	always_comb
	begin
		next_s        = s;
		k             = s.edg + 5'h01;
		rxv           = s.rx;
		byte_v        = s.rx;
		bdone         = 1'b0;
		next_s.ss_m   = SEL_N_I;
		next_s.ss_s   = s.ss_m;
		next_s.miso_m = MISO_I;
		next_s.miso_s = s.miso_m;
		next_s.tg_m   = lnk_tgl;
		next_s.tg_s   = s.tg_m;
		next_s.tg_d   = s.tg_s;
		// status access arms clears; data access finishes done and collision, control write finishes fault
		if (STATUS_ACC)
		begin
			next_s.overrun_flag = 1'b0;
			if (s.transfer_done_flag || s.write_collision_flag)
				next_s.arm = 1'b1;
			if (s.master_fault_flag)
				next_s.master_fault_flag_arm = 1'b1;
		end
		if ((DATA_RD || DATA_WR) && s.arm)
		begin
			next_s.transfer_done_flag = 1'b0;
			next_s.write_collision_flag = 1'b0;
			next_s.arm  = 1'b0;
		end
		if (CTRL_WR)
		begin
			if (s.master_fault_flag && !s.master_fault_flag_arm)
			begin
				next_s.master_select_bit = 1'b0;
				next_s.port_enable_bit  = 1'b0;
			end
			else
			begin
				next_s.master_select_bit     = CTRL_MASTER;
				next_s.port_enable_bit      = CTRL_ENABLE;
				next_s.master_fault_flag     = 1'b0;
				next_s.master_fault_flag_arm = 1'b0;
			end
		end
		// master engine: one step per half period of SCK
		if (s.st == sms_pkg::SMS_RUN)
		begin
			if (s.tmr == half - 7'h01)
			begin
				next_s.tmr = '0;
				next_s.edg = k;
				if (k <= sms_pkg::EDGE_SCK)
					next_s.sck = ~s.sck;
				if (k[0] == clock_sample_phase && k >= cap_min)
					rxv = {s.rx[6:0], s.miso_s};
				// phase 1 keeps bit 7 through the first edge
				if (k[0] == clock_sample_phase && k >= cap_min && k <= tx_max)
				begin
					next_s.tx   = {s.tx[6:0], 1'b0};
					next_s.mosi = s.tx[6];
				end
				if (k == sms_pkg::EDGE_END)
				begin
					next_s.st = sms_pkg::SMS_IDLE;
					bdone     = 1'b1;
					byte_v    = rxv;
				end
			end
			else
				next_s.tmr = s.tmr + 7'h01;
		end
		next_s.rx = rxv;
		// slave byte end, seen through the toggle crossing
		if (s.tg_s ^ s.tg_d)
		begin
			bdone          = 1'b1;
			byte_v         = lnk_word;
			next_s.ss_seen = 1'b0;
		end
		if (ss_int)
			next_s.ss_seen = 1'b1;
		if (bdone)
		begin
			if (next_s.transfer_done_flag)
				next_s.overrun_flag = 1'b1;
			else
				next_s.rdata = byte_v;
			next_s.transfer_done_flag = 1'b1;
		end
		// data write: blocked, collision, or accepted
		if (DATA_WR && !blocked)
		begin
			if (s.st == sms_pkg::SMS_RUN)
				next_s.write_collision_flag = 1'b1;
			else if (s.lnk_en && !clock_sample_phase && (!s.ss_seen || !ss_int))
				next_s.write_collision_flag = 1'b1;
			else
			begin
				next_s.hold = DATA_WDATA;
				if (s.master_select_bit && s.port_enable_bit)
				begin
					next_s.st   = sms_pkg::SMS_RUN;
					next_s.tx   = DATA_WDATA;
					next_s.mosi = DATA_WDATA[7];
					next_s.tmr  = '0;
					next_s.edg  = '0;
				end
			end
		end
		// master needs select high; low select is a fault
		if (next_s.master_select_bit && !ss_int)
		begin
			if (s.master_select_bit && s.port_enable_bit)
				next_s.master_fault_flag = 1'b1;
			next_s.master_select_bit = 1'b0;
			next_s.port_enable_bit  = 1'b0;
		end
		if (!next_s.master_select_bit || !next_s.port_enable_bit)
			next_s.st = sms_pkg::SMS_IDLE;
		if (next_s.st == sms_pkg::SMS_IDLE)
			next_s.sck = clock_idle_polarity;
		next_s.lnk_en  = next_s.port_enable_bit && !next_s.master_select_bit;
		next_s.sck_oe  = next_s.port_enable_bit && next_s.master_select_bit;
		next_s.miso_oe = next_s.lnk_en && !ss_int;
		next_s.busy    = (next_s.st == sms_pkg::SMS_RUN)
			|| next_s.miso_oe;
		next_s.irq     = PORT_INTERRUPT_ENABLE
			&& (next_s.transfer_done_flag || next_s.master_fault_flag || next_s.overrun_flag);
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s         <= '0;
			s.ss_seen <= 1'b1;
			s.ss_m    <= 1'b1;
			s.ss_s    <= 1'b1;
			s.rdata   <= sms_pkg::BYTE_RST;
		end
		else
			s <= next_s;
	end

	// ****************
	// * outputs
	// ****************
	assign SCK_O                = s.sck;
	assign SCK_OE               = s.sck_oe;
	assign MOSI_O               = s.mosi;
	assign MOSI_OE              = s.sck_oe;
	assign MISO_O               = miso_lnk;
	assign MISO_OE              = s.miso_oe;
	assign DATA_RDATA           = s.rdata;
	assign TRANSFER_DONE_FLAG   = s.transfer_done_flag;
	assign WRITE_COLLISION_FLAG = s.write_collision_flag;
	assign MASTER_FAULT_FLAG    = s.master_fault_flag;
	assign OVERRUN_FLAG         = s.overrun_flag;
	assign MASTER_SELECT_BIT    = s.master_select_bit;
	assign PORT_ENABLE_BIT      = s.port_enable_bit;
	assign IRQ                  = s.irq;
	assign BUSY                 = s.busy;

	// ****************
	// * checks
	// ****************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	AST_MSB_FIRST: assert property (
		(s.st == sms_pkg::SMS_IDLE && next_s.st == sms_pkg::SMS_RUN)
		|=> MOSI_O == $past(DATA_WDATA[7]) && MOSI_OE)
		else $error("first master bit is not the msb");

	AST_SLAVE_NO_SCK: assert property (
		!MASTER_SELECT_BIT |-> !SCK_OE)
		else $error("slave drives SCK");

	AST_FAST_RATE: assert property (
		(s.st == sms_pkg::SMS_RUN && BIT_RATE_SELECT == 3'h0
		&& $changed(s.sck)) |=> $stable(s.sck))
		else $error("SCK half period shorter than two cycles");

	AST_BYTE_TIME: assert property (
		($rose(s.st == sms_pkg::SMS_RUN) && BIT_RATE_SELECT == 3'h0
		&& SELECT_SOFTWARE_MANAGED && SELECT_INTERNAL_LEVEL)
		|-> ##34 (s.st == sms_pkg::SMS_IDLE && TRANSFER_DONE_FLAG))
		else $error("master byte did not end after 34 cycles");

	AST_FAULT: assert property (
		(s.master_select_bit && s.port_enable_bit && !ss_int)
		|=> MASTER_FAULT_FLAG && !PORT_ENABLE_BIT && !MASTER_SELECT_BIT)
		else $error("select low as master without fault");

	AST_SOFT_SEL: assert property (
		(SELECT_SOFTWARE_MANAGED && SELECT_INTERNAL_LEVEL
		&& s.master_select_bit && s.port_enable_bit && !CTRL_WR) |=> PORT_ENABLE_BIT)
		else $error("select pin not ignored under software select");

	AST_OVERRUN: assert property (
		(bdone && s.transfer_done_flag && !((DATA_RD || DATA_WR) && s.arm))
		|=> OVERRUN_FLAG && $stable(DATA_RDATA))
		else $error("overrun not flagged or old byte replaced");

	AST_COLLIDE: assert property (
		(DATA_WR && !blocked && s.st == sms_pkg::SMS_RUN)
		|=> WRITE_COLLISION_FLAG && $stable(s.hold)
		&& s.st == $past(s.st))
		else $error("write during transfer not discarded");

	AST_DONE_SET: assert property (
		bdone |=> TRANSFER_DONE_FLAG ##1 (TRANSFER_DONE_FLAG
		|| $past(DATA_RD || DATA_WR)))
		else $error("done flag not set at byte end");
endmodule : sms_port

// >>> dv/sms_peer.sv
// sms_peer: far end of the four-wire link, slave or master by task
// assumes: bench gives the same polarity and phase as the port uses
`timescale 1ns/1ps
module sms_peer
(
	// port side pins
	input  wire logic sck_o,
	input  wire logic sck_oe,
	input  wire logic mosi_o,
	input  wire logic mosi_oe,
	input  wire logic miso_o,
	input  wire logic miso_oe,
	// agreed timing mode
	input  wire logic clock_idle_polarity,
	input  wire logic clock_sample_phase,
	// resolved lines
	output      logic sck,
	output      logic mosi,
	output      logic miso,
	output      logic sel_n
);
	logic       m_on   = 1'b0;
	logic       s_on   = 1'b0;
	logic       m_sck  = 1'b0;
	logic       m_mosi = 1'b0;
	logic       s_out  = 1'b0;
	logic       flt    = 1'b0;
	logic       sel_r  = 1'b1;
	logic [7:0] tx     = 8'h00;
	logic [7:0] rx     = 8'h00;
	int         nb     = 0;

	// released data lines show a moving pattern, not a stale level; released SCK rests at idle level
	always #20 flt = ~flt;
	assign sck   = sck_oe ? sck_o : (m_on ? m_sck : clock_idle_polarity);
	assign mosi  = mosi_oe ? mosi_o : (m_on ? m_mosi : flt);
	assign miso  = miso_oe ? miso_o : (s_on ? s_out : flt);
	assign sel_n = sel_r;

	// ****************
	// * slave end: sample on one edge, shift on the other
	// ****************
	always @(sck)
		if (s_on)
		begin
			if ((sck != clock_idle_polarity) ^ clock_sample_phase)
				rx = {rx[6:0], mosi};
			else
			begin
				if (!clock_sample_phase)
					nb++;
				s_out = (nb < 8) ? tx[7 - nb] : flt;
				if (clock_sample_phase)
					nb++;
			end
		end

	task automatic load(input logic [7:0] d, input logic on);
		tx    = d;
		rx    = 8'h00;
		nb    = 0;
		s_out = d[7];
		s_on  = on;
	endtask : load

	task automatic set_sel(input logic v);
		sel_r = v;
	endtask : set_sel

	// master end, link clock of 48 ns, still between frames
	task automatic xfer(input logic [7:0] d, input logic use_sel,
		output logic [7:0] got);
		m_sck = clock_idle_polarity;
		m_on  = 1'b1;
		sel_r = !use_sel;
		#200;
		for (int i = 0; i < 8; i++)
		begin
			if (!clock_sample_phase)
				m_mosi = d[7 - i];
			#24;
			if (!clock_sample_phase)
				got = {got[6:0], miso};
			m_sck = ~clock_idle_polarity;
			if (clock_sample_phase)
				m_mosi = d[7 - i];
			#24;
			if (clock_sample_phase)
				got = {got[6:0], miso};
			m_sck = clock_idle_polarity;
		end
		#24;
		sel_r = 1'b1;
		m_on  = 1'b0;
		// gap between bytes leaves software time to clear flags
		#200;
	endtask : xfer
endmodule : sms_peer

// >>> dv/tb_top.sv
// tb_top: self-checking bench of the serial master/slave port
// assumes: sms_peer stands at the link and resolves the shared lines
`timescale 1ns/1ps
module tb_top;
	localparam logic [3:0] CW = 4'h8;
	localparam logic [3:0] SA = 4'h4;
	localparam logic [3:0] DW = 4'h2;
	localparam logic [3:0] DR = 4'h1;
	logic       clk, arst_n, clock_idle_polarity, clock_sample_phase, select_software_managed, select_internal_level, pie;
	logic       c_wr, c_m, c_e, st_acc, d_wr, d_rd;
	logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic       sck, mosi, miso, sel_n, done, write_collision_flag, master_fault_flag, overrun_flag;
	logic       master_select_bit, port_enable_bit, irq, busy;
	logic [2:0] rate;
	logic [7:0] wdata, rdata, got;
	int         n_mismatch = 0;
	int         total_checks = 0;

	sms_port dut
	(
		.CLK(clk), .ARST_N(arst_n),
		.SCK_I(sck), .SCK_O(sck_o), .SCK_OE(sck_oe),
		.MOSI_I(mosi), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
		.MISO_I(miso), .MISO_O(miso_o), .MISO_OE(miso_oe),
		.SEL_N_I(sel_n), .CLOCK_IDLE_POLARITY(clock_idle_polarity),
		.CLOCK_SAMPLE_PHASE(clock_sample_phase), .BIT_RATE_SELECT(rate),
		.SELECT_SOFTWARE_MANAGED(select_software_managed), .SELECT_INTERNAL_LEVEL(select_internal_level),
		.PORT_INTERRUPT_ENABLE(pie), .CTRL_WR(c_wr), .CTRL_MASTER(c_m),
		.CTRL_ENABLE(c_e), .STATUS_ACC(st_acc), .DATA_WR(d_wr),
		.DATA_WDATA(wdata), .DATA_RD(d_rd), .DATA_RDATA(rdata),
		.TRANSFER_DONE_FLAG(done), .WRITE_COLLISION_FLAG(write_collision_flag),
		.MASTER_FAULT_FLAG(master_fault_flag), .OVERRUN_FLAG(overrun_flag),
		.MASTER_SELECT_BIT(master_select_bit), .PORT_ENABLE_BIT(port_enable_bit), .IRQ(irq),
		.BUSY(busy)
	);

	sms_peer peer
	(
		.sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_o(miso_o), .miso_oe(miso_oe), .clock_idle_polarity(clock_idle_polarity), .clock_sample_phase(clock_sample_phase),
		.sck(sck), .mosi(mosi), .miso(miso), .sel_n(sel_n)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************
	// * shared tasks
	// ****************
	task automatic chk(input string what, input logic [7:0] exp, got_v);
		total_checks++;
		if (got_v !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got_v);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// one strobe pulse, then settle before the caller looks
	task automatic cpu(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		{c_wr, st_acc, d_wr, d_rd} <= s;
		{c_m, c_e} <= d[1:0];
		wdata <= d;
		@(posedge clk);
		{c_wr, st_acc, d_wr, d_rd} <= 4'h0;
		@(posedge clk);
		@(negedge clk);
	endtask : cpu

	task automatic clear();
		cpu(SA, 8'h00);
		cpu(DR, 8'h00);
	endtask : clear

	task automatic wait_done();
		int n;
		n = 0;
		while (done !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 4000)
			begin
				n_mismatch++;
				$display("MISMATCH done flag expected 1 seen %b", done);
				final_report();
			end
		end
	endtask : wait_done

	// ****************
	// * scenarios
	// ****************
	task automatic master_rates();
		realtime    t0;
		int         n;
		int         sh;
		logic [7:0] d;
		cpu(CW, 8'h03);
		chk("master on", 8'h03, 8'({master_select_bit, port_enable_bit}));
		// codes 6 and 7 run at the slowest rate
		for (int i = 0; i < 8; i++)
		begin
			d = 8'h5A ^ 8'(i * 37);
			sh = (i > 5) ? 5 : i;
			@(posedge clk);
			{clock_idle_polarity, clock_sample_phase, rate, pie} <= {i[0], i[1], 3'(i), !i[2]};
			repeat (3) @(negedge clk);
			chk("idle clock", 8'({1'b1, clock_idle_polarity}), 8'({sck_oe, sck}));
			peer.load(~d, 1'b1);
			t0 = $realtime;
			cpu(DW, d);
			cpu(DW, ~d);
			chk("collision", 8'h02, 8'({write_collision_flag, irq}));
			wait_done();
			n = int'(($realtime - t0) / 40.0);
			chk("rate", 8'h01, 8'(n >= (34 << sh) && n <= (34 << sh) + 4));
			chk("rx byte", ~d, rdata);
			chk("tx byte", d, peer.rx);
			chk("irq", 8'(pie), 8'(irq));
			cpu(DW, 8'h3C);
			chk("blocked", 8'h00, 8'(busy));
			clear();
			chk("cleared", 8'h00, 8'({done, write_collision_flag}));
			peer.load(8'h00, 1'b0);
		end
	endtask : master_rates

	task automatic fault();
		@(posedge clk);
		{select_software_managed, pie} <= 2'b01;
		repeat (3) @(negedge clk);
		peer.set_sel(1'b0);
		repeat (5) @(negedge clk);
		chk("fault", 8'h09, 8'({master_fault_flag, master_select_bit, port_enable_bit, irq}));
		peer.set_sel(1'b1);
		repeat (3) @(negedge clk);
		cpu(CW, 8'h03);
		chk("refused", 8'h09, 8'({master_fault_flag, master_select_bit, port_enable_bit, irq}));
		cpu(SA, 8'h00);
		cpu(CW, 8'h03);
		chk("restored", 8'h06, 8'({master_fault_flag, master_select_bit, port_enable_bit, irq}));
	endtask : fault

	task automatic slave();
		cpu(CW, 8'h00);
		@(posedge clk);
		{clock_idle_polarity, clock_sample_phase} <= 2'b00;
		cpu(CW, 8'h01);
		cpu(DW, 8'hC3);
		chk("slave idle", 8'h00, 8'({write_collision_flag, busy, sck_oe}));
		peer.xfer(8'h69, 1'b1, got);
		chk("slave out", 8'hC3, got);
		wait_done();
		chk("slave in", 8'h69, rdata);
		clear();
		cpu(CW, 8'h00);
		@(posedge clk);
		{clock_idle_polarity, clock_sample_phase, select_software_managed, select_internal_level} <= 4'b1110;
		cpu(CW, 8'h01);
		cpu(DW, 8'h5A);
		peer.xfer(8'h81, 1'b0, got);
		chk("soft select", 8'h5A, got);
		peer.xfer(8'h7E, 1'b0, got);
		wait_done();
		chk("overrun data", 8'h81, rdata);
		chk("overrun flag", 8'h01, 8'(overrun_flag));
		clear();
		chk("overrun clear", 8'h00, 8'({overrun_flag, done}));
		cpu(CW, 8'h00);
		@(posedge clk);
		clock_sample_phase <= 1'b0;
		cpu(CW, 8'h01);
		cpu(DW, 8'h11);
		chk("select low write", 8'h01, 8'(write_collision_flag));
	endtask : slave

	initial
	begin
		{c_wr, c_m, c_e, st_acc, d_wr, d_rd} = 6'h00;
		{clock_idle_polarity, clock_sample_phase, select_software_managed, select_internal_level, pie} = 5'b00111;
		rate   = 3'h0;
		wdata  = 8'h00;
		arst_n = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk("reset flags", 8'h00, {done, write_collision_flag, master_fault_flag, overrun_flag, master_select_bit, port_enable_bit, irq, busy});
		chk("reset data", 8'h00, rdata);
		master_rates();
		fault();
		slave();
		final_report();
	end
endmodule : tb_top
